// File: testbench/ovp_host_side.sv
`timescale 1ns/100ps
// far side of the supervisor: the measured input rail and the pulled-up alert wire
module ovp_host_side (
    input wire logic clk_i,
    input wire logic [4:0] exp_i,
    input wire logic [10:0] man_i,
    input wire logic alert_line_n_i,
    input wire logic alert_line_n_oe_i,
    output logic [15:0] vin_o,
    output logic alert_wire_o
);
    // rail word changes only on a clock edge, like a converter result
    always_ff @(posedge clk_i) begin
        vin_o <= {exp_i, man_i};
    end

    // open drain: the pull-up wins whenever the device lets go
    assign alert_wire_o = alert_line_n_oe_i ? alert_line_n_i : 1'b1;
endmodule

// File: testbench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import ovp_pkg::*;
    // short retry unit keeps the 35 ms steps down to 20 cycles each
    localparam int U = 20;
    localparam logic [15:0] V_LO = 16'hd300;
    localparam logic [15:0] V_MID = 16'hd370;
    localparam logic [15:0] V_HI = 16'hd3c0;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [ADR_W-1:0] wb_adr = '0;
    logic [DAT_W-1:0] wb_wdat = '0;
    logic [DAT_W-1:0] wb_dat_o;
    logic wb_ack_o;
    logic [15:0] vin_w = V_LO;
    logic [15:0] vin;
    logic en_pin = 1'b1;
    logic bias_ok = 1'b1;
    logic other_fault = 1'b0;
    logic output_en_o;
    logic alert_n;
    logic alert_oe;
    logic alert_wire;
    logic irq_o;
    int failures = 0;
    int samples_checked = 0;

    // 50 MHz
    always #10 clk = ~clk;

    ovp_monitor #(.RETRY_UNIT_CYC(U)) uut (
        .clk_i(clk), .rst_i(rst), .ce_i(1'b1),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(4'h3), .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .vin_i(vin), .en_pin_i(en_pin), .bias_ok_i(bias_ok), .other_fault_i(other_fault),
        .output_en_o(output_en_o), .alert_line_n_o(alert_n), .alert_line_n_oe_o(alert_oe),
        .irq_o(irq_o)
    );

    ovp_host_side host (
        .clk_i(clk), .exp_i(vin_w[15:11]), .man_i(vin_w[10:0]),
        .alert_line_n_i(alert_n), .alert_line_n_oe_i(alert_oe),
        .vin_o(vin), .alert_wire_o(alert_wire)
    );

    task automatic end_sim();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one classic cycle; request held until ack is sampled high
    task automatic bus(input logic we, input logic [7:0] idx, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {idx, 2'b00};
        wb_wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        if (n >= 20) begin
            check("bus ack", 1'b0, 1'b1);
            end_sim();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] q);
        bus(1'b0, idx, 32'h0, q);
    endtask

    task automatic set_v(input logic [15:0] w);
        @(posedge clk);
        vin_w <= w;
    endtask

    // bounded wait for the output enable; a timeout ends the run
    task automatic wait_en(input logic val, input int lim, output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (output_en_o !== val && n < lim);
        if (output_en_o !== val) begin
            check("output_en wait", output_en_o, val);
            end_sim();
        end
    endtask

    task automatic t_reset();
        logic [31:0] q;
        int n;
        rd(IDX_ACTION, q);
        check("action reset", q, 32'h80);
        rd(IDX_WARN, q);
        check("warn reset", q, 32'hd360);
        rd(IDX_FAULT_LIM, q);
        check("fault limit reset", q, 32'hd380);
        wait_en(1'b1, 10, n);
    endtask

    task automatic t_warn();
        logic [31:0] q;
        wr(IDX_MASK, 32'h2);
        set_v(V_MID);
        repeat (5) @(posedge clk);
        rd(IDX_STATUS, q);
        check("warn status", q, 32'he);
        check("warn alert wire", alert_wire, 1'b0);
        check("warn irq", irq_o, 1'b1);
        check("warn keeps output", output_en_o, 1'b1);
        set_v(V_LO);
        repeat (4) @(posedge clk);
        wr(IDX_STATUS, 32'h2);
        repeat (2) @(posedge clk);
        check("irq after w1c", irq_o, 1'b0);
        wr(IDX_MASK, 32'h0);
        wr(IDX_CTRL, 32'h5);
    endtask

    task automatic t_hold();
        logic [31:0] q;
        int n;
        wr(IDX_ACTION, 32'hc0);
        set_v(V_HI);
        wait_en(1'b0, 6, n);
        rd(IDX_STATUS, q);
        check("hold fault flag", q[SB_FLT], 1'b1);
        check("hold alert wire", alert_wire, 1'b0);
        set_v(V_MID);
        repeat (10) @(posedge clk);
        check("hold above warn", output_en_o, 1'b0);
        set_v(V_LO);
        wait_en(1'b1, 6, n);
        rd(IDX_STATUS, q);
        check("flag sticky", q[SB_FLT], 1'b1);
        wr(IDX_CTRL, 32'h5);
        repeat (2) @(posedge clk);
        rd(IDX_STATUS, q);
        check("status cleared", q, 32'h0);
        check("alert released", alert_wire, 1'b1);
    endtask

    task automatic t_noretry();
        int n;
        wr(IDX_ACTION, 32'h80);
        set_v(V_HI);
        wait_en(1'b0, 6, n);
        set_v(V_LO);
        repeat (100) @(posedge clk);
        check("no retry stays off", output_en_o, 1'b0);
        wr(IDX_CTRL, 32'h5);
        wait_en(1'b1, 4, n);
    endtask

    task automatic t_retry();
        int n;
        int exp_n;
        logic [2:0] codes[3] = '{3'h0, 3'h2, 3'h7};
        // successive attempts, each spaced by (code+1) units
        foreach (codes[i]) begin
            exp_n = (int'(codes[i]) + 1) * U;
            wr(IDX_ACTION, {24'h0, 8'hb8 | {5'h0, codes[i]}});
            set_v(V_HI);
            wait_en(1'b0, 6, n);
            set_v(V_LO);
            wait_en(1'b1, exp_n + 10, n);
            check("retry spacing", (n >= exp_n - 2 && n <= exp_n + 2), 1'b1);
            wr(IDX_CTRL, 32'h5);
        end
        // an attempt waits for the rail to fall under the warning level
        set_v(V_HI);
        wait_en(1'b0, 6, n);
        set_v(V_MID);
        // wait past the longest delay so only the warning level holds it off
        repeat (9 * U) @(posedge clk);
        check("retry above warn", output_en_o, 1'b0);
        set_v(V_LO);
        wait_en(1'b1, 6, n);
        wr(IDX_CTRL, 32'h5);
    endtask

    task automatic t_shut();
        int n;
        // a pending continuous retry is dropped once the pin commands off
        set_v(V_HI);
        wait_en(1'b0, 6, n);
        @(posedge clk);
        en_pin <= 1'b0;
        set_v(V_LO);
        repeat (10 * U) @(posedge clk);
        check("retry stopped by pin", output_en_o, 1'b0);
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            en_pin <= (k != 0);
            bias_ok <= (k != 1);
            other_fault <= (k == 2);
            wait_en(1'b0, 8, n);
            @(posedge clk);
            en_pin <= 1'b1;
            bias_ok <= 1'b1;
            other_fault <= 1'b0;
            wait_en(1'b1, 8, n);
        end
        wr(IDX_CTRL, 32'h0);
        wait_en(1'b0, 4, n);
        wr(IDX_CTRL, 32'h1);
        wait_en(1'b1, 4, n);
    endtask

    task automatic t_rsvd();
        logic [31:0] q;
        logic [7:0] codes[3] = '{8'h40, 8'h00, 8'h90};
        foreach (codes[i]) begin
            wr(IDX_ACTION, {24'h0, codes[i]});
            set_v(V_HI);
            repeat (8) @(posedge clk);
            check("reserved keeps output", output_en_o, 1'b1);
            rd(IDX_STATUS, q);
            check("reserved fault flag", q[SB_FLT], 1'b1);
            set_v(V_LO);
            repeat (3) @(posedge clk);
            wr(IDX_CTRL, 32'h5);
        end
    endtask

    task automatic t_wp();
        logic [31:0] q;
        wr(IDX_ACTION, 32'h80);
        wr(IDX_CTRL, 32'h3);
        wr(IDX_ACTION, 32'hc0);
        wr(IDX_WARN, 32'h1234);
        rd(IDX_ACTION, q);
        check("action protected", q, 32'h80);
        rd(IDX_WARN, q);
        check("warn protected", q, 32'hd360);
        wr(IDX_CTRL, 32'h1);
    endtask

    task automatic t_format();
        logic [31:0] q;
        // 13.5 V with exponent -4 against a rail word with exponent -6
        wr(IDX_WARN, 32'he0d8);
        set_v(V_MID);
        repeat (4) @(posedge clk);
        rd(IDX_LIVE, q);
        check("warn above", q[2], 1'b1);
        set_v(16'hd350);
        repeat (4) @(posedge clk);
        rd(IDX_LIVE, q);
        check("warn below", q[2], 1'b0);
        set_v(V_LO);
        wr(IDX_WARN, 32'hd360);
        wr(IDX_CTRL, 32'h5);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_warn();
        t_hold();
        t_noretry();
        t_retry();
        t_shut();
        t_rsvd();
        t_wp();
        t_format();
        end_sim();
    end
endmodule

// File: verilog/ovp_l11_cmp.sv
`timescale 1ns/100ps
module ovp_l11_cmp (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [ovp_pkg::L11_W-1:0] lhs_i,
    input wire logic [ovp_pkg::L11_W-1:0] rhs_i,
    output logic gt_o
);
    import ovp_pkg::*;

    // linear-11 to signed fixed point with FIX_FRAC fraction bits
    function automatic logic signed [FIX_W-1:0] l11_fix(input logic [L11_W-1:0] w);
        logic signed [EXP_HI-EXP_LO:0] n;
        logic signed [MAN_HI:0] y;
        logic signed [FIX_W-1:0] ys;
        logic [5:0] sh;
        n = w[EXP_HI:EXP_LO]; // R13
        y = w[MAN_HI:0]; // R13
        ys = FIX_W'(y);
        sh = 6'(n + FIX_FRAC);
        return ys <<< sh; // R10
    endfunction

    // registered so the compare does not sit in the fsm path
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gt_o <= 1'b0;
        end else if (ce_i) begin
            gt_o <= l11_fix(lhs_i) > l11_fix(rhs_i);
        end
    end
endmodule

// File: verilog/ovp_monitor.sv
`timescale 1ns/100ps
// Contract
// R1 - code 10: shut off, then follow retry field
// R2 - code 11: off while fault, resume below warning
// R3 - fault pulls alert low, sets sticky flag
// R4 - retry 000: stay off until fault cleared
// R5 - retry 111: retry until commanded off/fault
// R6 - continuous retry starts only below warning
// R7 - attempt spacing is (code+1) times 35 ms
// R8 - warning sets summary, input, warn flags; alert
// R9 - action register resets 80h, write protected
// R10 - warning threshold is two-byte linear-11 value
// R11 - warning resets D360h, write protected
// R12 - fault above fault threshold, reset D380h
// R13 - exponent bits 15:11, mantissa bits 10:0
// R14 - reserved codes start no shutdown or restart
module ovp_monitor #(
    parameter int RETRY_UNIT_CYC = ovp_pkg::RETRY_UNIT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ovp_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [ovp_pkg::SEL_W-1:0] wb_sel_i,
    input wire logic [ovp_pkg::DAT_W-1:0] wb_dat_i,
    output logic [ovp_pkg::DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [ovp_pkg::L11_W-1:0] vin_i,
    input wire logic en_pin_i,
    input wire logic bias_ok_i,
    input wire logic other_fault_i,
    output logic output_en_o,
    output logic alert_line_n_o,
    output logic alert_line_n_oe_o,
    output logic irq_o
);
    import ovp_pkg::*;

    typedef enum logic [2:0] {
        ST_ON,
        ST_LATCH,
        ST_HOLD,
        ST_RETRY,
        ST_OFF_CMD
    } ovp_state_t;

    ovp_state_t state;
    ovp_state_t next_state;

    logic [7:0] action;
    logic [L11_W-1:0] warn_lim;
    logic [L11_W-1:0] fault_lim;
    logic [SB_W-1:0] status;
    logic [SB_W-1:0] next_status;
    logic [SB_W-1:0] mask;
    logic op_on;
    logic wp;
    logic [SYNC_W-1:0] en_sync;
    logic [SYNC_W-1:0] bias_sync;
    logic fault_hi;
    logic warn_hi;
    logic tmr_idle;
    logic tmr_load;
    logic req;
    logic wr;
    logic cfg_wr;
    logic clr_cmd;
    logic [SB_W-1:0] w1c;
    logic [SB_W-1:0] set_bits;
    logic shut;
    logic [1:0] act;
    logic [2:0] rty;
    logic trip;

    // address decode against a register index
    function automatic logic hit(input logic [ADR_W-1:0] a, input logic [IDX_W-1:0] idx);
        return a[ADR_W-1:2] == idx;
    endfunction

    // byte-lane merge for the two-byte registers
    function automatic logic [L11_W-1:0] merge16(input logic [L11_W-1:0] old,
                                                 input logic [L11_W-1:0] dat,
                                                 input logic [1:0] sel);
        logic [L11_W-1:0] r;
        r = old;
        for (int i = 0; i < 2; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // pins from outside the clock domain go through two flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_sync <= '0;
            bias_sync <= '0;
        end else if (ce_i) begin
            en_sync <= {en_sync[0], en_pin_i};
            bias_sync <= {bias_sync[0], bias_ok_i};
        end
    end

    // threshold compares; vin comes from same-clock measurement logic
    ovp_l11_cmp u_fault_cmp (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .lhs_i(vin_i),
        .rhs_i(fault_lim),
        .gt_o(fault_hi)
    );

    ovp_l11_cmp u_warn_cmp (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .lhs_i(vin_i),
        .rhs_i(warn_lim),
        .gt_o(warn_hi)
    );

    ovp_retry_timer #(
        .UNIT_CYC(RETRY_UNIT_CYC)
    ) u_retry_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .load_i(tmr_load),
        .code_i(action[DLY_HI:DLY_LO]),
        .idle_o(tmr_idle)
    );

    // bus strobes; ack is held off one cycle so each request answers once
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i;
    assign cfg_wr = wr && !wp; // R9
    assign clr_cmd = wr && hit(wb_adr_i, IDX_CTRL) && wb_sel_i[0] && wb_dat_i[CB_CLR];
    assign w1c = (wr && hit(wb_adr_i, IDX_STATUS) && wb_sel_i[0]) ? wb_dat_i[SB_W-1:0] : '0;

    // wishbone answer: one wait state, unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else if (ce_i) begin
            wb_ack_o <= req;
            wb_dat_o <= '0;
            if (req && !wb_we_i) begin
                if (hit(wb_adr_i, IDX_FAULT_LIM)) begin
                    wb_dat_o <= DAT_W'(fault_lim);
                end else if (hit(wb_adr_i, IDX_ACTION)) begin
                    wb_dat_o <= DAT_W'(action);
                end else if (hit(wb_adr_i, IDX_WARN)) begin
                    wb_dat_o <= DAT_W'(warn_lim);
                end else if (hit(wb_adr_i, IDX_STATUS)) begin
                    wb_dat_o <= DAT_W'(status);
                end else if (hit(wb_adr_i, IDX_MASK)) begin
                    wb_dat_o <= DAT_W'(mask);
                end else if (hit(wb_adr_i, IDX_CTRL)) begin
                    wb_dat_o <= DAT_W'({wp, op_on});
                end else if (hit(wb_adr_i, IDX_LIVE)) begin
                    wb_dat_o <= DAT_W'({bias_sync[1], en_sync[1], warn_hi, fault_hi,
                                        output_en_o});
                end
            end
        end
    end

    // protected configuration; writes are dropped while wp is set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            action <= RST_ACTION; // R9
            warn_lim <= RST_WARN; // R11
            fault_lim <= RST_FAULT; // R12
        end else if (ce_i && cfg_wr) begin
            if (hit(wb_adr_i, IDX_ACTION) && wb_sel_i[0]) begin
                action <= wb_dat_i[7:0];
            end
            if (hit(wb_adr_i, IDX_WARN)) begin
                warn_lim <= merge16(warn_lim, wb_dat_i[L11_W-1:0], wb_sel_i[1:0]); // R10
            end
            if (hit(wb_adr_i, IDX_FAULT_LIM)) begin
                fault_lim <= merge16(fault_lim, wb_dat_i[L11_W-1:0], wb_sel_i[1:0]);
            end
        end
    end

    // control and mask; clear command is a write-only pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            op_on <= 1'b1;
            wp <= 1'b0;
            mask <= RST_MASK;
        end else if (ce_i) begin
            if (wr && hit(wb_adr_i, IDX_CTRL) && wb_sel_i[0]) begin
                op_on <= wb_dat_i[CB_OP];
                wp <= wb_dat_i[CB_WP];
            end
            if (wr && hit(wb_adr_i, IDX_MASK) && wb_sel_i[0]) begin
                mask <= wb_dat_i[SB_W-1:0];
            end
        end
    end

    // sticky flags: a set in the same cycle as a clear wins
    always_comb begin
        set_bits = '0;
        set_bits[SB_FLT] = fault_hi; // R3
        set_bits[SB_WRN] = warn_hi; // R8
        set_bits[SB_INP] = warn_hi || fault_hi; // R8
        set_bits[SB_NOA] = warn_hi; // R8
        next_status = status & ~w1c;
        if (clr_cmd) begin
            next_status = '0; // R3
        end
        next_status = next_status | set_bits;
    end

    // alert pin is open drain: enable pulls it low while any flag stands
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= '0;
            alert_line_n_oe_o <= 1'b0;
            irq_o <= 1'b0;
        end else if (ce_i) begin
            status <= next_status;
            alert_line_n_oe_o <= |next_status; // R3
            irq_o <= |(next_status & mask);
        end
    end
    assign alert_line_n_o = 1'b0;

    // response decode; reserved codes never trip the output
    assign act = action[ACT_HI:ACT_LO];
    assign rty = action[RTY_HI:RTY_LO];
    assign shut = !(op_on && en_sync[1] && bias_sync[1]) || other_fault_i; // R5
    assign trip = fault_hi && (act == ACT_HOLD || // R12
                  (act == ACT_RETRY && (rty == RTY_NONE || rty == RTY_CONT))); // R14
    assign tmr_load = (state == ST_ON) && (next_state == ST_RETRY);

    // output sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            ST_ON: begin
                if (shut) begin
                    next_state = ST_OFF_CMD;
                end else if (trip) begin
                    if (act == ACT_HOLD) begin
                        next_state = ST_HOLD; // R2
                    end else if (rty == RTY_NONE) begin
                        next_state = ST_LATCH; // R1
                    end else begin
                        next_state = ST_RETRY; // R1
                    end
                end
            end
            ST_LATCH: begin
                // stays off across commands until the host clears the fault
                if (clr_cmd && !fault_hi) begin
                    next_state = ST_ON; // R4
                end
            end
            ST_HOLD: begin
                if (shut) begin
                    next_state = ST_OFF_CMD;
                end else if (!warn_hi) begin
                    next_state = ST_ON; // R2
                end
            end
            ST_RETRY: begin
                if (shut) begin
                    next_state = ST_OFF_CMD; // R5
                end else if (tmr_idle && !warn_hi) begin
                    next_state = ST_ON; // R6
                end
            end
            ST_OFF_CMD: begin
                if (!shut) begin
                    next_state = ST_ON;
                end
            end
        endcase
    end

    // state and output enable share the same edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_OFF_CMD;
            output_en_o <= 1'b0;
        end else if (ce_i) begin
            state <= next_state;
            output_en_o <= (next_state == ST_ON);
        end
    end

    sequence s_live_fault;
        ce_i && state == ST_ON && !shut && fault_hi;
    endsequence

    sequence s_latch_trip;
        s_live_fault ##0 (act == ACT_RETRY && rty == RTY_NONE);
    endsequence

    sequence s_cont_trip;
        s_live_fault ##0 (act == ACT_RETRY && rty == RTY_CONT);
    endsequence

    sequence s_hold_release;
        ce_i && state == ST_HOLD && !shut && !warn_hi;
    endsequence

    a_latch_entry: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        s_latch_trip |=> state == ST_LATCH && !output_en_o)
        else $error("no-retry trip did not latch the output off");
    a_latch_holds: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        ce_i && state == ST_LATCH && !clr_cmd |=> state == ST_LATCH && !output_en_o)
        else $error("latched output restarted without a fault clear");
    a_cont_trip: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        s_cont_trip |=> state == ST_RETRY && !tmr_idle)
        else $error("continuous retry trip did not arm the delay");
    a_hold_release: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        s_hold_release |=> output_en_o)
        else $error("hold mode did not resume below warning");
    a_retry_gate: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        ce_i && state == ST_RETRY && (warn_hi || !tmr_idle) |=> !output_en_o)
        else $error("retry started above warning or early");
    a_retry_stop: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        ce_i && state == ST_RETRY && shut |=> state == ST_OFF_CMD)
        else $error("continuous retry ignored a shutdown cause");
    a_fault_flag: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        ce_i && fault_hi |=> status[SB_FLT] && alert_line_n_oe_o)
        else $error("fault did not set flag and pull alert");
    a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        ce_i && status[SB_FLT] && !clr_cmd && !w1c[SB_FLT] |=> status[SB_FLT])
        else $error("fault flag dropped without a clear");
    a_warn_flags: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        ce_i && warn_hi |=> status[SB_WRN] && status[SB_INP] && status[SB_NOA] &&
        (irq_o || !$past(|mask[SB_NOA:SB_WRN])))
        else $error("warning did not set its flags");
    a_reset_vals: assert property (@(posedge clk_i) // R9
        rst_i |=> action == RST_ACTION && warn_lim == RST_WARN && fault_lim == RST_FAULT)
        else $error("configuration reset values wrong");
    a_rsvd_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // R14
        s_live_fault ##0 !trip |=> state == ST_ON && output_en_o)
        else $error("reserved response code shut the output");
    a_protect: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        ce_i && wp |=> $stable(warn_lim) && $stable(action))
        else $error("protected configuration changed");
endmodule

// File: verilog/ovp_pkg.sv
package ovp_pkg;
    // wishbone geometry: 32-bit data, one register per aligned word
    localparam int ADR_W = 10;
    localparam int IDX_W = 8;
    localparam int DAT_W = 32;
    localparam int SEL_W = 4;
    localparam int L11_W = 16;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_FAULT_LIM = 8'h55;
    localparam logic [IDX_W-1:0] IDX_ACTION = 8'h56;
    localparam logic [IDX_W-1:0] IDX_WARN = 8'h57;
    localparam logic [IDX_W-1:0] IDX_STATUS = 8'h78;
    localparam logic [IDX_W-1:0] IDX_MASK = 8'h79;
    localparam logic [IDX_W-1:0] IDX_CTRL = 8'h7a;
    localparam logic [IDX_W-1:0] IDX_LIVE = 8'h7b;

    // reset values
    localparam logic [7:0] RST_ACTION = 8'h80;
    localparam logic [L11_W-1:0] RST_WARN = 16'hd360;
    localparam logic [L11_W-1:0] RST_FAULT = 16'hd380;

    // action register fields
    localparam int ACT_HI = 7;
    localparam int ACT_LO = 6;
    localparam int RTY_HI = 5;
    localparam int RTY_LO = 3;
    localparam int DLY_HI = 2;
    localparam int DLY_LO = 0;
    localparam int DLY_W = DLY_HI - DLY_LO + 1;
    localparam logic [1:0] ACT_RETRY = 2'h2;
    localparam logic [1:0] ACT_HOLD = 2'h3;
    localparam logic [2:0] RTY_NONE = 3'h0;
    localparam logic [2:0] RTY_CONT = 3'h7;

    // status / mask bits, control bits, live state bits
    localparam int SB_FLT = 0;
    localparam int SB_WRN = 1;
    localparam int SB_INP = 2;
    localparam int SB_NOA = 3;
    localparam int SB_W = 4;
    localparam logic [SB_W-1:0] RST_MASK = 4'h0;
    localparam int CB_OP = 0;
    localparam int CB_WP = 1;
    localparam int CB_CLR = 2;
    localparam int LB_W = 5;

    // linear-11 layout and fixed-point compare width
    localparam int EXP_HI = 15;
    localparam int EXP_LO = 11;
    localparam int MAN_HI = 10;
    localparam int FIX_W = 48;
    localparam int FIX_FRAC = 16;

    // retry timing
    localparam int CLK_HZ = 50_000_000;
    localparam int MS_PER_S = 1000;
    localparam int RETRY_UNIT_MS = 35;
    localparam int RETRY_UNIT_CYC = CLK_HZ / MS_PER_S * RETRY_UNIT_MS;
    localparam int CNT_W = 24;
    localparam int SYNC_W = 2;
endpackage

// File: verilog/ovp_retry_timer.sv
`timescale 1ns/100ps
module ovp_retry_timer #(
    parameter int UNIT_CYC = ovp_pkg::RETRY_UNIT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic load_i,
    input wire logic [ovp_pkg::DLY_W-1:0] code_i,
    output logic idle_o
);
    import ovp_pkg::*;

    logic [CNT_W-1:0] cnt;
    logic [31:0] span;
    logic [CNT_W-1:0] span_c;

    // (code + 1) units between attempt starts
    assign span = (32'(code_i) + 32'h1) * 32'(UNIT_CYC); // R7
    assign span_c = span[CNT_W-1:0];
    assign idle_o = (cnt == '0);

    // down counter; a load restarts it even while running
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= '0;
        end else if (ce_i) begin
            if (load_i) begin
                cnt <= span_c; // R7
            end else if (cnt != '0) begin
                cnt <= cnt - 1'b1;
            end
        end
    end

    a_delay_load: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        ce_i && load_i |=> cnt == $past(span_c))
        else $error("retry delay not loaded with (code+1) units");
    a_delay_step: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        ce_i && !load_i && cnt != '0 |=> cnt == CNT_W'($past(cnt) - 1'b1))
        else $error("retry delay did not count down by one");
endmodule
